// ===== design/nmg_node.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module nmg_node
#(
    parameter int INIT_CYCLES = nmg_pkg::NMG_INIT_CYCLES,
    parameter int TICK_CYCLES = nmg_pkg::NMG_TICK_CYCLES
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [6:0] node_id_in,
    // received frame strobe from the CAN controller (same clock)
    input wire logic rx_valid_in,
    input wire logic [10:0] rx_id_in,
    input wire logic rx_rtr_in,
    input wire logic [3:0] rx_dlc_in,
    input wire logic [7:0] rx_byte0_in,
    input wire logic [7:0] rx_byte1_in,
    // frame toward the CAN controller
    output logic tx_valid_out,
    output logic [10:0] tx_id_out,
    output logic [3:0] tx_dlc_out,
    output logic [7:0] tx_data_out,
    input wire logic tx_ready_in,
    // object class gates
    output logic pdo_en_out,
    output logic sdo_en_out,
    output logic sync_en_out,
    output logic emcy_en_out,
    output logic nmt_en_out,
    output logic dev_reset_out,
    output logic comm_reset_out,
    output logic comm_loss_alarm_out,
    output logic [6:0] state_code_out,
    // avalon-mm slave
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    typedef enum logic [2:0] {NMG_INIT, NMG_BOOT, NMG_PREOP, NMG_OPER, NMG_STOPPED} nmg_state_t;

    nmg_state_t state;
    logic [15:0] init_cnt;
    logic [15:0] guard_interval_ms;
    logic [7:0] miss_count_factor;
    logic hb_enable;
    logic avs_done;
    logic [31:0] tick_cnt;
    logic tick_1ms;
    logic guard_run;
    logic [15:0] ms_cnt;
    logic [7:0] miss_cnt;
    logic toggle;
    logic guard_err;
    logic guard_pend;
    logic cmd_hit;
    logic poll_hit;
    logic guard_cfg;
    logic wr_guard;
    logic [15:0] reg_idx;

    nmg_tx_if tx_if();

    nmg_tx_framer u_framer
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .node_id_in(node_id_in),
        .tx(tx_if.framer),
        .tx_valid_out(tx_valid_out),
        .tx_id_out(tx_id_out),
        .tx_dlc_out(tx_dlc_out),
        .tx_data_out(tx_data_out),
        .tx_ready_in(tx_ready_in)
    );

    // ----------------
    // frame decode
    // ----------------
    // commands are silently dropped while initializing
    assign cmd_hit = rx_valid_in && !rx_rtr_in && rx_id_in == nmg_pkg::NMG_ID_NMT
        && rx_dlc_in >= 4'h2 && state != NMG_INIT && state != NMG_BOOT
        && (rx_byte1_in == 8'h00 || rx_byte1_in == {1'b0, node_id_in});
    assign poll_hit = rx_valid_in && rx_rtr_in && rx_dlc_in == 4'h0
        && rx_id_in == (nmg_pkg::NMG_ID_ERRCTL | {4'h0, node_id_in})
        && (state == NMG_PREOP || state == NMG_OPER || state == NMG_STOPPED);
    assign guard_cfg = guard_interval_ms != 16'h0000 && miss_count_factor != 8'h00 && !hb_enable;

    // ----------------
    // node state machine
    // ----------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state <= NMG_INIT;
            init_cnt <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            case (state)
                NMG_INIT:
                begin
                    if (init_cnt == 16'(INIT_CYCLES - 1))
                        state <= NMG_BOOT;
                    else
                        init_cnt <= init_cnt + 16'h0001;
                end
                NMG_BOOT:
                begin
                    if (!tx_if.busy)
                        state <= NMG_PREOP;
                end
                default:
                begin
                    if (guard_err)
                        state <= NMG_PREOP;
                    else if (cmd_hit)
                    begin
                        case (rx_byte0_in)
                            nmg_pkg::NMG_CMD_START: state <= NMG_OPER;
                            nmg_pkg::NMG_CMD_STOP: state <= NMG_STOPPED;
                            nmg_pkg::NMG_CMD_PREOP: state <= NMG_PREOP;
                            nmg_pkg::NMG_CMD_RESET_NODE, nmg_pkg::NMG_CMD_RESET_COMM:
                            begin
                                state <= NMG_INIT;
                                init_cnt <= 16'h0000;
                            end
                            default: state <= state;
                        endcase
                    end
                end
            endcase
        end
    end

    // one-cycle reset strobes to the rest of the device
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            dev_reset_out <= 1'b0;
            comm_reset_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            dev_reset_out <= cmd_hit && !guard_err && rx_byte0_in == nmg_pkg::NMG_CMD_RESET_NODE;
            comm_reset_out <= cmd_hit && !guard_err && rx_byte0_in == nmg_pkg::NMG_CMD_RESET_COMM;
        end
    end

    // ----------------
    // class gates and state code
    // ----------------
    always_comb
    begin
        pdo_en_out = state == NMG_OPER;
        sdo_en_out = state == NMG_OPER || state == NMG_PREOP;
        sync_en_out = sdo_en_out;
        emcy_en_out = sdo_en_out;
        nmt_en_out = state == NMG_OPER || state == NMG_PREOP || state == NMG_STOPPED;
        case (state)
            NMG_OPER: state_code_out = nmg_pkg::NMG_CODE_OPER;
            NMG_STOPPED: state_code_out = nmg_pkg::NMG_CODE_STOPPED;
            default: state_code_out = nmg_pkg::NMG_CODE_PREOP;
        endcase
    end

    // ----------------
    // transmit requests: boot-up and poll answers only, never a command reply
    // ----------------
    // a poll arriving while the framer is full is dropped; the master sees a miss
    always_comb
    begin
        tx_if.req = 1'b0;
        tx_if.kind = nmg_pkg::NMG_TX_NONE;
        tx_if.data = {toggle, state_code_out};
        if (state == NMG_BOOT)
        begin
            tx_if.req = 1'b1;
            tx_if.kind = nmg_pkg::NMG_TX_BOOT;
        end
        else if (poll_hit)
        begin
            tx_if.req = 1'b1;
            tx_if.kind = nmg_pkg::NMG_TX_GUARD;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            toggle <= 1'b0;
        else if (clk_en_in)
        begin
            if (state == NMG_INIT)
                toggle <= 1'b0;
            else if (poll_hit && !tx_if.busy && state != NMG_BOOT)
                toggle <= ~toggle;
        end
    end

    // ----------------
    // 1 ms tick
    // ----------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tick_cnt <= 32'h0000_0000;
            tick_1ms <= 1'b0;
        end
        else if (clk_en_in)
        begin
            tick_1ms <= tick_cnt == 32'(TICK_CYCLES - 1);
            if (tick_cnt == 32'(TICK_CYCLES - 1))
                tick_cnt <= 32'h0000_0000;
            else
                tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    // ----------------
    // life guarding supervision
    // ----------------
    // the tick is free running, so the first interval can be up to 1 ms short
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            guard_run <= 1'b0;
            ms_cnt <= 16'h0000;
            miss_cnt <= 8'h00;
            guard_pend <= 1'b0;
        end
        else if (clk_en_in)
        begin
            guard_pend <= 1'b0;
            if (!guard_cfg || state == NMG_INIT)
            begin
                guard_run <= 1'b0;
                ms_cnt <= 16'h0000;
                miss_cnt <= 8'h00;
            end
            else if (poll_hit)
            begin
                guard_run <= 1'b1;
                ms_cnt <= 16'h0000;
                miss_cnt <= 8'h00;
            end
            else if (guard_run && tick_1ms)
            begin
                if (ms_cnt == guard_interval_ms - 16'h0001)
                begin
                    ms_cnt <= 16'h0000;
                    if (miss_cnt == miss_count_factor - 8'h01)
                    begin
                        guard_pend <= 1'b1;
                        guard_run <= 1'b0;
                        miss_cnt <= 8'h00;
                    end
                    else
                        miss_cnt <= miss_cnt + 8'h01;
                end
                else
                    ms_cnt <= ms_cnt + 16'h0001;
            end
        end
    end

    assign guard_err = guard_pend && guard_cfg;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            comm_loss_alarm_out <= 1'b0;
        else if (clk_en_in)
        begin
            if (guard_err)
                comm_loss_alarm_out <= 1'b1;
            else if (wr_guard)
                comm_loss_alarm_out <= 1'b0;
        end
    end

    // ----------------
    // register bus
    // ----------------
    assign reg_idx = {2'b00, avs_address_in[15:2]};
    // a write that re-enables guarding: both values end up non-zero
    assign wr_guard = avs_write_in && !avs_done && !hb_enable
        && ((reg_idx == nmg_pkg::NMG_IDX_GUARD_INTERVAL && avs_writedata_in[15:0] >= nmg_pkg::NMG_MIN_GUARD_MS
             && miss_count_factor != 8'h00 && avs_byteenable_in[1:0] == 2'b11)
            || (reg_idx == nmg_pkg::NMG_IDX_MISS_FACTOR && avs_writedata_in[7:0] != 8'h00
             && guard_interval_ms != 16'h0000 && avs_byteenable_in[0]));
    // one wait cycle per access, answer on the second edge
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !avs_done;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            avs_done <= 1'b0;
        else if (clk_en_in)
            avs_done <= (avs_read_in || avs_write_in) && !avs_done;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || (clk_en_in && state == NMG_INIT))
        begin
            guard_interval_ms <= nmg_pkg::NMG_RST_GUARD_INTERVAL;
            miss_count_factor <= nmg_pkg::NMG_RST_MISS_FACTOR;
            hb_enable <= 1'b0;
        end
        else if (clk_en_in && avs_write_in && !avs_done)
        begin
            case (reg_idx)
                nmg_pkg::NMG_IDX_GUARD_INTERVAL:
                begin
                    // zero disables; values 1 ms are refused
                    if (avs_byteenable_in[1:0] == 2'b11 && (avs_writedata_in[15:0] == 16'h0000
                        || avs_writedata_in[15:0] >= nmg_pkg::NMG_MIN_GUARD_MS))
                        guard_interval_ms <= avs_writedata_in[15:0];
                end
                nmg_pkg::NMG_IDX_MISS_FACTOR:
                begin
                    if (avs_byteenable_in[0])
                        miss_count_factor <= avs_writedata_in[7:0];
                end
                nmg_pkg::NMG_IDX_CONTROL:
                begin
                    // heartbeat can only be switched on while guarding is off
                    if (avs_byteenable_in[0])
                        hb_enable <= avs_writedata_in[nmg_pkg::NMG_CTL_HB_EN_BIT]
                            && (guard_interval_ms == 16'h0000 || miss_count_factor == 8'h00);
                end
                default: hb_enable <= hb_enable;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (clk_en_in && avs_read_in && !avs_done)
        begin
            case (reg_idx)
                nmg_pkg::NMG_IDX_GUARD_INTERVAL: avs_readdata_out <= {16'h0000, guard_interval_ms};
                nmg_pkg::NMG_IDX_MISS_FACTOR: avs_readdata_out <= {24'h00_0000, miss_count_factor};
                nmg_pkg::NMG_IDX_CONTROL: avs_readdata_out <= {31'h0000_0000, hb_enable};
                nmg_pkg::NMG_IDX_STATUS: avs_readdata_out <= {23'h00_0000, guard_run, comm_loss_alarm_out,
                    state_code_out};
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule // nmg_node

// ===== design/nmg_pkg.sv
// ----------------
// How it works
// ----------------
// How it works
// - after reset enter initialization silently, then go to preoperational automatically
// - leaving initialization, send one boot-up frame, id 700h plus node, one zero byte
// - preoperational passes SDO, SYNC, EMCY and NMT; PDO traffic is blocked
// - operational passes every object class
// - stopped passes only NMT traffic, both directions
// - state commands use id 00h, byte 1 command code, byte 2 destination node
// - no reply is ever sent for a state command
// - code 1 operational, code 2 stopped, code 128 preoperational
// - code 129 full reset, code 130 communication reset, both repeat initialization
// - act on destination 0 or own node number, ignore all others
// - hold a 16-bit guard interval in milliseconds between master polls
// - error only after consecutive misses reach the 8-bit factor
// - a zero interval or zero factor disables guarding and its error
// - supervision timing starts only at the first poll received
// - poll answer carries one byte, state in bits 6..0: 4, 5 or 127
// - bit 7 of the answer inverts against the previous answer
// - guarding error forces preoperational and raises the comm loss alarm
// - guarding answers and supervision continue in stopped
// - re-enabling guarding after an error clears the alarm
// - nonzero guard intervals below 2 ms are not accepted
// - heartbeat and node guarding are never enabled together
package nmg_pkg;
    // ----------------
    // register map (byte addresses = 4 x index)
    // ----------------
    localparam logic [15:0] NMG_IDX_GUARD_INTERVAL = 16'h100C;
    localparam logic [15:0] NMG_IDX_MISS_FACTOR = 16'h100D;
    localparam logic [15:0] NMG_IDX_CONTROL = 16'h100E;
    localparam logic [15:0] NMG_IDX_STATUS = 16'h100F;
    localparam logic [15:0] NMG_RST_GUARD_INTERVAL = 16'h0000;
    localparam logic [7:0] NMG_RST_MISS_FACTOR = 8'h00;
    localparam int NMG_CTL_HB_EN_BIT = 0;
    localparam int NMG_STS_ALARM_BIT = 7;
    localparam int NMG_STS_GUARD_RUN_BIT = 8;
    localparam logic [15:0] NMG_MIN_GUARD_MS = 16'h0002;
    // ----------------
    // frame identifiers and codes
    // ----------------
    localparam logic [10:0] NMG_ID_NMT = 11'h000;
    localparam logic [10:0] NMG_ID_ERRCTL = 11'h700;
    localparam logic [7:0] NMG_CMD_START = 8'h01;
    localparam logic [7:0] NMG_CMD_STOP = 8'h02;
    localparam logic [7:0] NMG_CMD_PREOP = 8'h80;
    localparam logic [7:0] NMG_CMD_RESET_NODE = 8'h81;
    localparam logic [7:0] NMG_CMD_RESET_COMM = 8'h82;
    localparam logic [6:0] NMG_CODE_STOPPED = 7'h04;
    localparam logic [6:0] NMG_CODE_OPER = 7'h05;
    localparam logic [6:0] NMG_CODE_PREOP = 7'h7F;
    // ----------------
    // timing
    // ----------------
    localparam int NMG_CLK_HZ = 100_000_000;
    localparam int NMG_TICK_US = 1000;
    localparam int NMG_TICK_CYCLES = NMG_CLK_HZ / 1_000_000 * NMG_TICK_US;
    localparam int NMG_INIT_CYCLES = 16;

    typedef enum logic [1:0] {NMG_TX_NONE, NMG_TX_BOOT, NMG_TX_GUARD} nmg_tx_kind_t;
endpackage

// ===== design/nmg_tx_if.sv
`timescale 1ns/1ps
interface nmg_tx_if;
    logic req;
    nmg_pkg::nmg_tx_kind_t kind;
    logic [7:0] data;
    logic busy;
    modport core (output req, output kind, output data, input busy);
    modport framer (input req, input kind, input data, output busy);
endinterface

// ===== design/nmg_tx_framer.sv
`timescale 1ns/1ps
module nmg_tx_framer
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [6:0] node_id_in,
    nmg_tx_if.framer tx,
    output logic tx_valid_out,
    output logic [10:0] tx_id_out,
    output logic [3:0] tx_dlc_out,
    output logic [7:0] tx_data_out,
    input wire logic tx_ready_in
);
    // ----------------
    // single frame holding register toward the controller
    // ----------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_valid_out <= 1'b0;
            tx_id_out <= 11'h000;
            tx_dlc_out <= 4'h0;
            tx_data_out <= 8'h00;
        end
        else if (clk_en_in)
        begin
            if (tx_valid_out && tx_ready_in)
                tx_valid_out <= 1'b0;
            else if (tx.req && !tx_valid_out && tx.kind != nmg_pkg::NMG_TX_NONE)
            begin
                tx_valid_out <= 1'b1;
                tx_id_out <= nmg_pkg::NMG_ID_ERRCTL | {4'h0, node_id_in};
                tx_dlc_out <= 4'h1;
                tx_data_out <= (tx.kind == nmg_pkg::NMG_TX_BOOT) ? 8'h00 : tx.data;
            end
        end
    end

    assign tx.busy = tx_valid_out;
endmodule // nmg_tx_framer

// ===== test/nmg_node_properties.sv
`timescale 1ns/1ps
module nmg_node_properties
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [6:0] node_id_in,
    input wire logic rx_valid_in,
    input wire logic [10:0] rx_id_in,
    input wire logic rx_rtr_in,
    input wire logic [3:0] rx_dlc_in,
    input wire logic [7:0] rx_byte0_in,
    input wire logic [7:0] rx_byte1_in,
    input wire logic tx_valid_out,
    input wire logic [10:0] tx_id_out,
    input wire logic [3:0] tx_dlc_out,
    input wire logic [7:0] tx_data_out,
    input wire logic pdo_en_out,
    input wire logic sdo_en_out,
    input wire logic sync_en_out,
    input wire logic emcy_en_out,
    input wire logic nmt_en_out,
    input wire logic [6:0] state_code_out
);
    // ----------------
    // helpers
    // ----------------
    logic [10:0] own_id;
    logic svc_on;
    logic cmd_ok;
    logic poll_ok;
    logic tgl_seen;
    logic tgl_last;
    assign own_id = 11'h700 + {4'h0, node_id_in};
    assign svc_on = sdo_en_out && sync_en_out && emcy_en_out;
    assign cmd_ok = rx_valid_in && nmt_en_out && rx_id_in == 11'h000 && !rx_rtr_in && rx_dlc_in >= 4'h2
        && (rx_byte1_in == 8'h00 || rx_byte1_in == {1'b0, node_id_in});
    assign poll_ok = rx_valid_in && nmt_en_out && rx_rtr_in && rx_dlc_in == 4'h0 && rx_id_in == own_id && !tx_valid_out;
    // toggle history restarts at init; the boot frame is no poll answer
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || !nmt_en_out)
            tgl_seen <= 1'b0;
        else if ($rose(tx_valid_out) && !$rose(nmt_en_out))
        begin
            tgl_seen <= 1'b1;
            tgl_last <= tx_data_out[7];
        end
    end
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_init_quiet: assert property (!nmt_en_out |-> !pdo_en_out && !sdo_en_out && state_code_out == 7'h7F)
        else $error("traffic open in init");
    a_boot_frame: assert property ($rose(nmt_en_out) |-> $rose(tx_valid_out) && tx_id_out == own_id
        && tx_dlc_out == 4'h1 && tx_data_out == 8'h00) else $error("boot frame wrong");
    a_preop_gates: assert property (nmt_en_out && state_code_out == 7'h7F |-> !pdo_en_out && svc_on)
        else $error("preop gates wrong");
    a_oper_gates: assert property (state_code_out == 7'h05 |-> pdo_en_out && svc_on && nmt_en_out)
        else $error("oper gates wrong");
    a_stop_gates: assert property (state_code_out == 7'h04 |-> nmt_en_out && !pdo_en_out && !sdo_en_out
        && !sync_en_out && !emcy_en_out) else $error("stop gates wrong");
    a_cmd_state: assert property (cmd_ok && rx_byte0_in inside {8'h01, 8'h02, 8'h80} |=> state_code_out ==
        ($past(rx_byte0_in) == 8'h01 ? 7'h05 : $past(rx_byte0_in) == 8'h02 ? 7'h04 : 7'h7F))
        else $error("command state wrong");
    a_no_reply: assert property (cmd_ok && !tx_valid_out |=> !tx_valid_out)
        else $error("reply to command");
    a_poll_reply: assert property (poll_ok |=> tx_valid_out && tx_id_out == own_id && tx_dlc_out == 4'h1
        && tx_data_out[6:0] == $past(state_code_out)) else $error("poll reply wrong");
    a_toggle_flip: assert property ($rose(tx_valid_out) && nmt_en_out && tgl_seen |-> tx_data_out[7] != tgl_last)
        else $error("toggle not inverted");
endmodule // nmg_node_properties

bind nmg_node nmg_node_properties i_props (.*);

// ===== test/nmg_can_master.sv
`timescale 1ns/1ps
module nmg_can_master
(
    input wire logic clk_in,
    input wire logic tx_valid_in,
    input wire logic [3:0] lag_in,
    output logic rx_valid_out,
    output logic [10:0] rx_id_out,
    output logic rx_rtr_out,
    output logic [3:0] rx_dlc_out,
    output logic [7:0] rx_b0_out,
    output logic [7:0] rx_b1_out,
    output logic tx_ready_out
);
    int held = 0;
    initial
    begin
        rx_valid_out = 1'b0;
        {rx_id_out, rx_rtr_out, rx_dlc_out, rx_b0_out, rx_b1_out} = 32'h5A5A_A5A5;
        tx_ready_out = 1'b0;
    end
    // ----------------
    // frames toward the node
    // ----------------
    // fields are inverted once the strobe drops so stale sampling shows up
    task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [7:0] b0,
        input logic [7:0] b1);
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        {rx_id_out, rx_rtr_out, rx_dlc_out, rx_b0_out, rx_b1_out} <= {id, rtr, dlc, b0, b1};
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        {rx_id_out, rx_rtr_out, rx_dlc_out, rx_b0_out, rx_b1_out} <= ~{id, rtr, dlc, b0, b1};
    endtask
    task automatic command(input logic [7:0] code, input logic [7:0] dest);
        send(11'h000, 1'b0, 4'h2, code, dest);
    endtask
    task automatic poll(input logic [6:0] node);
        send(11'h700 + {4'h0, node}, 1'b1, 4'h0, 8'h3C, 8'hC3);
    endtask
    // ----------------
    // frames from the node, taken after lag_in plus one stalled cycles
    // ----------------
    always @(posedge clk_in)
    begin
        if (tx_ready_out || !tx_valid_in)
        begin
            tx_ready_out <= 1'b0;
            held <= 0;
        end
        else if (held >= lag_in)
            tx_ready_out <= 1'b1;
        else
            held <= held + 1;
    end
endmodule // nmg_can_master

// ===== test/nmg_node_tb.sv
`timescale 1ns/1ps
module nmg_node_tb;
    // ----------------
    // design and far side
    // ----------------
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [6:0] node_id_in, state_code_out;
    logic [10:0] rx_id_in, tx_id_out;
    logic [3:0] rx_dlc_in, tx_dlc_out, lag;
    logic [7:0] rx_byte0_in, rx_byte1_in, tx_data_out, d;
    logic rx_valid_in, rx_rtr_in, tx_valid_out, tx_ready_in, pdo_en_out, sdo_en_out, sync_en_out, emcy_en_out;
    logic nmt_en_out, dev_reset_out, comm_reset_out, comm_loss_alarm_out, avs_waitrequest_out, exp_tgl;
    logic [15:0] avs_address_in = 16'h0000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [3:0] avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out, g, f;
    logic [7:0] codes [3] = '{8'h01, 8'h02, 8'h80};
    logic [6:0] states [3] = '{7'h05, 7'h04, 7'h7F};
    int seed = 32'h1B4BB913;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    nmg_node #(.INIT_CYCLES(16), .TICK_CYCLES(10)) i_dut (.*);
    nmg_can_master i_master (.clk_in(clk_in), .tx_valid_in(tx_valid_out), .lag_in(lag), .rx_valid_out(rx_valid_in),
        .rx_id_out(rx_id_in), .rx_rtr_out(rx_rtr_in), .rx_dlc_out(rx_dlc_in), .rx_b0_out(rx_byte0_in),
        .rx_b1_out(rx_byte1_in), .tx_ready_out(tx_ready_in));
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a read compares its data against dat at the edge that ends the wait
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] dat, input string what = "");
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= dat;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        if (!wr)
            chk(what, dat, avs_readdata_out);
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic wait_tx(output logic [7:0] dat);
        do @(negedge clk_in); while (tx_valid_out !== 1'b1);
        chk("tx_id", 11'h700 + {4'h0, node_id_in}, tx_id_out);
        chk("tx_dlc", 32'h1, tx_dlc_out);
        dat = tx_data_out;
        do @(negedge clk_in); while (tx_valid_out !== 1'b0);
    endtask
    task automatic poll_chk(input logic [6:0] code);
        i_master.poll(node_id_in);
        wait_tx(d);
        chk("reply_state", code, d[6:0]);
        chk("toggle", exp_tgl, d[7]);
        exp_tgl = !exp_tgl;
    endtask
    task automatic boot_chk;
        chk("init_nmt", 32'h0, nmt_en_out);
        wait_tx(d);
        chk("boot_data", 32'h0, d);
        exp_tgl = 1'b0;
        repeat (2) @(negedge clk_in);
        chk("state", 7'h7F, state_code_out);
        chk("pdo", 32'h0, pdo_en_out);
        chk("sdo", 32'h1, sdo_en_out);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    initial
    begin
        node_id_in = 7'h01 + 7'($unsigned($random(seed)) % 126);
        lag = 4'($unsigned($random(seed)) % 4);
        g = 2 + $unsigned($random(seed)) % 3;
        f = 2 + $unsigned($random(seed)) % 2;
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        boot_chk();
        $display("test boot done");
        for (int i = 0; i < 3; i++)
        begin
            i_master.command(codes[i], ($random(seed) & 1) ? 8'h00 : {1'b0, node_id_in});
            @(negedge clk_in);
            chk("state", states[i], state_code_out);
            poll_chk(states[i]);
        end
        i_master.command(8'h01, {1'b0, node_id_in} + 8'h01);
        i_master.command(8'h01, 8'h80 | {1'b0, node_id_in});
        i_master.command(8'h03, 8'h00);
        @(negedge clk_in);
        chk("state", 7'h7F, state_code_out);
        $display("test commands done");
        bus(1'b0, 16'h4030, 32'h0, "guard_rst");
        bus(1'b0, 16'h4034, 32'h0, "factor_rst");
        bus(1'b1, 16'h4030, 32'h1);
        bus(1'b0, 16'h4030, 32'h0, "guard_min");
        bus(1'b1, 16'h4030, g);
        bus(1'b1, 16'h4034, f);
        bus(1'b0, 16'h4030, g, "guard");
        bus(1'b0, 16'h4034, f, "factor");
        bus(1'b1, 16'h4038, 32'h1);
        bus(1'b0, 16'h4038, 32'h0, "hb_en");
        bus(1'b0, 16'h4100, 32'h0, "unmapped");
        $display("test registers done");
        repeat (g * f * 10 + 30) @(negedge clk_in);
        chk("alarm", 32'h0, comm_loss_alarm_out);
        i_master.command(8'h01, 8'h00);
        poll_chk(7'h05);
        repeat ((g * f - 1) * 10 - 10) @(negedge clk_in);
        chk("alarm", 32'h0, comm_loss_alarm_out);
        repeat (40) @(negedge clk_in);
        chk("alarm", 32'h1, comm_loss_alarm_out);
        chk("state", 7'h7F, state_code_out);
        bus(1'b0, 16'h403C, 32'h0000_00FF, "status");
        bus(1'b1, 16'h4034, f);
        repeat (2) @(negedge clk_in);
        chk("alarm", 32'h0, comm_loss_alarm_out);
        bus(1'b1, 16'h4034, 32'h0);
        bus(1'b1, 16'h4038, 32'h1);
        bus(1'b0, 16'h4038, 32'h1, "hb_on");
        poll_chk(7'h7F);
        repeat (150) @(negedge clk_in);
        chk("alarm", 32'h0, comm_loss_alarm_out);
        $display("test guarding done");
        i_master.command(8'h82, {1'b0, node_id_in});
        @(negedge clk_in);
        chk("comm_reset", 32'h1, comm_reset_out);
        boot_chk();
        bus(1'b0, 16'h4030, 32'h0, "guard_init");
        i_master.command(8'h81, 8'h00);
        @(negedge clk_in);
        chk("dev_reset", 32'h1, dev_reset_out);
        boot_chk();
        poll_chk(7'h7F);
        $display("test resets done");
        tally_and_finish();
    end
endmodule // nmg_node_tb
